// ==== verilog/lucc_channel_ctrl.sv ====
// Line unit channel control register, pattern generator and decode
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "lucc_defines.svh"
module lucc_channel_ctrl
    import lucc_pkg::*;
(
    // Clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_b,
    // Register port
    input  wire logic [`LUCC_AW-1:0]  i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    // Transmit data from the framer
    input  wire logic                 i_tx_pos,
    input  wire logic                 i_tx_neg,
    // Line receive pins
    input  wire logic                 i_line_rx_tip,
    input  wire logic                 i_line_rx_ring,
    // Line transmit pins
    output logic                      o_line_tx_tip,
    output logic                      o_line_tx_ring,
    output logic      [7:0]           o_tx_pulse_amp,
    // Receive outputs toward the framer
    output logic                      o_rx_positive_data_out,
    output logic                      o_rx_clock_out,
    output logic                      o_rx_power_down,
    // Equaliser decode
    output logic                      o_e1_mode,
    output logic                      o_coax,
    output lucc_haul_e                o_haul,
    output lucc_sens_e                o_rx_sens,
    output lucc_kind_e                o_lbo_kind,
    output logic      [2:0]           o_line_build_out
);

    function automatic lucc_eq_s eq_decode(input logic [4:0] c);
        lucc_eq_s d;
        d = '0;
        if (c >= `LUCC_EQ_E1) begin
            d.e1   = 1'b1;
            d.coax = ~c[0];
            d.kind = LUCC_G703;
            d.sens = lucc_sens_e'(c[2:1]);
            d.haul = (c[2:1] == 2'b11) ? LUCC_GAIN :
                     (c[2:1] == 2'b10) ? LUCC_SHORT : LUCC_LONG;
        end else if (c < `LUCC_EQ_SH0) begin
            d.haul = LUCC_LONG;
            d.sens = c[2] ? LUCC_S45 : LUCC_S36;
            d.kind = LUCC_ATTEN;
            d.line_build_out  = {1'b0, c[1:0]};
        end else if (c < `LUCC_EQ_GAIN0) begin
            d.haul = LUCC_SHORT;
            d.sens = LUCC_S15;
            d.kind = (c == `LUCC_EQ_SH_ARB) ? LUCC_ARB : LUCC_CABLE;
            d.line_build_out  = (c == `LUCC_EQ_SH_ARB) ? 3'h0 :
                     3'(c - `LUCC_EQ_SH0);
        end else begin
            d.haul = LUCC_GAIN;
            d.sens = LUCC_S29;
            if (c >= `LUCC_EQ_GAIN_LBO) begin
                d.kind = LUCC_ATTEN;
                d.line_build_out  = 3'(c - `LUCC_EQ_GAIN_LBO);
            end else if (c == `LUCC_EQ_GAIN_ARB) begin
                d.kind = LUCC_ARB;
            end else begin
                d.kind = LUCC_CABLE;
                d.line_build_out  = 3'(c - `LUCC_EQ_GAIN0);
            end
        end
        return d;
    endfunction

    // Registers
    logic [7:0]  ctrl_reg, ctrl_next;
    logic        gen_reg, gen_next;
    logic [7:0]  seg_reg [`LUCC_SEG_NUM];
    logic [7:0]  seg_next [`LUCC_SEG_NUM];
    logic [7:0]  rdata_next;
    logic        seg_hit;
    logic [2:0]  seg_idx;
    lucc_eq_s    eq;

    assign seg_hit = (i_addr >= `LUCC_ADDR_SEG0) &&
                     (i_addr <= `LUCC_ADDR_SEG7);
    assign seg_idx = i_addr[2:0];
    assign eq      = eq_decode(ctrl_reg[4:0]);

    always_comb begin
        ctrl_next  = ctrl_reg;
        gen_next   = gen_reg;
        seg_next   = seg_reg;
        rdata_next = 8'h00;
        if (i_wr) begin
            if (i_addr == `LUCC_ADDR_CTRL) begin
                ctrl_next = i_wdata;
            end
            if (i_addr == `LUCC_ADDR_GEN) begin
                gen_next = i_wdata[`LUCC_BIT_GEN];
            end
            if (seg_hit) begin
                seg_next[seg_idx] = i_wdata;
            end
        end
        if (i_rd) begin
            if (i_addr == `LUCC_ADDR_CTRL) begin
                rdata_next = ctrl_reg;
            end else if (i_addr == `LUCC_ADDR_STAT) begin
                rdata_next = {eq.e1, eq.coax, eq.haul, eq.sens,
                              eq.kind};
            end else if (i_addr == `LUCC_ADDR_GEN) begin
                rdata_next = {7'h00, gen_reg};
            end else if (seg_hit) begin
                rdata_next = seg_reg[seg_idx];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg <= `LUCC_CTRL_RST;
            gen_reg  <= 1'b0;
            seg_reg  <= '{default: 8'h00};
            o_rdata  <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            gen_reg  <= gen_next;
            seg_reg  <= seg_next;
            o_rdata  <= rdata_next;
        end
    end

    // Pattern generator, one bit per two clocks
    logic                    bit_en_reg, bit_en_next;
    logic [`LUCC_LFSR_W-1:0] lfsr_reg, lfsr_next;
    logic [`LUCC_LFSR_W-1:0] lfsr_act;
    logic                    fb;
    logic                    qrss;
    logic                    pat_bit;
    logic                    mark_pol_reg, mark_pol_next;

    assign qrss     = ctrl_reg[`LUCC_BIT_PTYPE];
    assign lfsr_act = qrss ? lfsr_reg : (lfsr_reg & `LUCC_PRBS_MASK);
    assign pat_bit  = qrss ? lfsr_reg[`LUCC_QRSS_TAPA] :
                             lfsr_reg[`LUCC_PRBS_TAPA];

    always_comb begin
        bit_en_next   = ~bit_en_reg;
        mark_pol_next = mark_pol_reg;
        lfsr_next     = lfsr_reg;
        fb = qrss ? (lfsr_reg[`LUCC_QRSS_TAPA] ^
                     lfsr_reg[`LUCC_QRSS_TAPB]) :
                    (lfsr_reg[`LUCC_PRBS_TAPA] ^
                     lfsr_reg[`LUCC_PRBS_TAPB]);
        if (bit_en_reg) begin
            if (lfsr_act == '0) begin
                lfsr_next = `LUCC_LFSR_SEED;
            end else begin
                lfsr_next = {lfsr_act[`LUCC_LFSR_W-2:0], fb};
            end
            if (pat_bit) begin
                mark_pol_next = ~mark_pol_reg;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_en_reg   <= 1'b0;
            lfsr_reg     <= `LUCC_LFSR_SEED;
            mark_pol_reg <= 1'b0;
        end else begin
            bit_en_reg   <= bit_en_next;
            lfsr_reg     <= lfsr_next;
            mark_pol_reg <= mark_pol_next;
        end
    end

    // Line receive pins pass two flip-flops
    logic [1:0] rx_meta_reg, rx_sync_reg;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_meta_reg <= 2'b00;
            rx_sync_reg <= 2'b00;
        end else begin
            rx_meta_reg <= {i_line_rx_tip, i_line_rx_ring};
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Output steering
    logic       rx_on;
    logic       to_rx;
    logic       to_tx;
    logic       tip_next, ring_next, rx_positive_data_out_next, rclk_next, pd_next;
    logic [7:0] amp_next;
    logic [2:0] seg_cnt_reg, seg_cnt_next;

    assign rx_on = ctrl_reg[`LUCC_BIT_RXON];
    assign to_rx = gen_reg && ctrl_reg[`LUCC_BIT_ROUTE];
    assign to_tx = gen_reg && !ctrl_reg[`LUCC_BIT_ROUTE];

    always_comb begin
        seg_cnt_next = seg_cnt_reg + 3'h1;
        pd_next      = !rx_on;
        if (to_tx) begin
            tip_next  = pat_bit && !mark_pol_reg;
            ring_next = pat_bit && mark_pol_reg;
        end else begin
            tip_next  = i_tx_pos;
            ring_next = i_tx_neg;
        end
        if (to_rx) begin
            rx_positive_data_out_next = pat_bit;
            rclk_next = bit_en_reg;
        end else if (rx_on) begin
            rx_positive_data_out_next = rx_sync_reg[1];
            rclk_next = bit_en_reg;
        end else begin
            rx_positive_data_out_next = 1'b0;
            rclk_next = 1'b0;
        end
        if (eq.kind == LUCC_ARB) begin
            amp_next = seg_reg[seg_cnt_reg];
        end else begin
            amp_next = 8'h00;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            seg_cnt_reg            <= 3'h0;
            o_line_tx_tip          <= 1'b0;
            o_line_tx_ring         <= 1'b0;
            o_tx_pulse_amp         <= 8'h00;
            o_rx_positive_data_out <= 1'b0;
            o_rx_clock_out         <= 1'b0;
            o_rx_power_down        <= 1'b1;
        end else begin
            seg_cnt_reg            <= seg_cnt_next;
            o_line_tx_tip          <= tip_next;
            o_line_tx_ring         <= ring_next;
            o_tx_pulse_amp         <= amp_next;
            o_rx_positive_data_out <= rx_positive_data_out_next;
            o_rx_clock_out         <= rclk_next;
            o_rx_power_down        <= pd_next;
        end
    end

    // Equaliser decode outputs
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_e1_mode        <= 1'b0;
            o_coax           <= 1'b0;
            o_haul           <= LUCC_LONG;
            o_rx_sens        <= LUCC_S36;
            o_lbo_kind       <= LUCC_ATTEN;
            o_line_build_out <= 3'h0;
        end else begin
            o_e1_mode        <= eq.e1;
            o_coax           <= eq.coax;
            o_haul           <= eq.haul;
            o_rx_sens        <= eq.sens;
            o_lbo_kind       <= eq.kind;
            o_line_build_out <= eq.line_build_out;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    sequence s_ctrl_write;
        i_wr && i_addr == `LUCC_ADDR_CTRL;
    endsequence

    property p_ptype;
        s_ctrl_write ##1 1'b1 |-> qrss == $past(i_wdata[`LUCC_BIT_PTYPE]);
    endproperty
    a_ptype: assert property (p_ptype)
        else $error("pattern type not taken from bit 7");

    property p_route_tx;
        to_tx ##1 to_tx |-> (o_line_tx_tip || o_line_tx_ring)
            == $past(pat_bit);
    endproperty
    a_route_tx: assert property (p_route_tx)
        else $error("pattern missing on line transmit pair");

    property p_route_rx;
        to_rx |=> o_rx_positive_data_out == $past(pat_bit);
    endproperty
    a_route_rx: assert property (p_route_rx)
        else $error("pattern missing on receive output");

    property p_rx_off;
        !rx_on && !to_rx |=> !o_rx_positive_data_out &&
            !o_rx_clock_out && o_rx_power_down;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("receive section active while off");

    property p_arb;
        eq.kind == LUCC_ARB |=>
            o_tx_pulse_amp == seg_reg[$past(seg_cnt_reg)];
    endproperty
    a_arb: assert property (p_arb)
        else $error("arbitrary amplitude not from segment");

    property p_long;
        ctrl_reg[4:0] < `LUCC_EQ_SH0 |=> o_haul == LUCC_LONG &&
            !o_e1_mode && o_line_build_out == $past(ctrl_reg[1:0]);
    endproperty
    a_long: assert property (p_long)
        else $error("T1 long haul decode wrong");

    property p_short_arb;
        ctrl_reg[4:0] == `LUCC_EQ_SH_ARB |=> o_haul == LUCC_SHORT &&
            o_rx_sens == LUCC_S15 && o_lbo_kind == LUCC_ARB;
    endproperty
    a_short_arb: assert property (p_short_arb)
        else $error("short haul arbitrary decode wrong");

    property p_gain;
        ctrl_reg[4:0] >= `LUCC_EQ_GAIN0 &&
            ctrl_reg[4:0] < `LUCC_EQ_E1 |=>
            o_haul == LUCC_GAIN && o_rx_sens == LUCC_S29;
    endproperty
    a_gain: assert property (p_gain)
        else $error("T1 gain decode wrong");

    property p_e1;
        ctrl_reg[4:0] >= `LUCC_EQ_E1 |=> o_e1_mode &&
            o_coax == !$past(ctrl_reg[0]);
    endproperty
    a_e1: assert property (p_e1)
        else $error("E1 cable decode wrong");

endmodule

// ==== verilog/lucc_defines.svh ====
// Constants of the line unit channel control block
`ifndef LUCC_DEFINES_SVH
`define LUCC_DEFINES_SVH
`define LUCC_AW          16
`define LUCC_ADDR_CTRL   16'h0f00
`define LUCC_ADDR_STAT   16'h0f01
`define LUCC_ADDR_GEN    16'h0f02
`define LUCC_ADDR_SEG0   16'h0f08
`define LUCC_ADDR_SEG7   16'h0f0f
`define LUCC_SEG_NUM     8
`define LUCC_CTRL_RST    8'h00
`define LUCC_BIT_PTYPE   7
`define LUCC_BIT_ROUTE   6
`define LUCC_BIT_RXON    5
`define LUCC_BIT_GEN     0
`define LUCC_EQ_E1       5'h18
`define LUCC_EQ_SH0      5'h08
`define LUCC_EQ_SH_ARB   5'h0d
`define LUCC_EQ_GAIN0    5'h0e
`define LUCC_EQ_GAIN_ARB 5'h13
`define LUCC_EQ_GAIN_LBO 5'h14
`define LUCC_LFSR_W      20
`define LUCC_LFSR_SEED   20'h0_0001
`define LUCC_PRBS_TAPA   14
`define LUCC_PRBS_TAPB   13
`define LUCC_PRBS_MASK   20'h0_7fff
`define LUCC_QRSS_TAPA   19
`define LUCC_QRSS_TAPB   16
`endif

// ==== verilog/lucc_pkg.sv ====
// Types of the line unit channel control block
package lucc_pkg;
    typedef enum logic [1:0] {
        LUCC_LONG  = 2'b00,
        LUCC_SHORT = 2'b01,
        LUCC_GAIN  = 2'b10
    } lucc_haul_e;
    typedef enum logic [1:0] {
        LUCC_S36 = 2'b00,
        LUCC_S45 = 2'b01,
        LUCC_S15 = 2'b10,
        LUCC_S29 = 2'b11
    } lucc_sens_e;
    typedef enum logic [1:0] {
        LUCC_ATTEN = 2'b00,
        LUCC_CABLE = 2'b01,
        LUCC_ARB   = 2'b10,
        LUCC_G703  = 2'b11
    } lucc_kind_e;
    typedef struct packed {
        logic       e1;
        logic       coax;
        lucc_haul_e haul;
        lucc_sens_e sens;
        lucc_kind_e kind;
        logic [2:0] line_build_out;
    } lucc_eq_s;
endpackage

// ==== tb/lucc_line_model.sv ====
// Line model: cable feeding alternating marks into the receive pair
`timescale 1ns/1ps
module lucc_line_model (
    // Clock and control
    input  wire logic i_mclk,
    input  wire logic i_send,
    // Receive pair toward the device
    output logic      o_rx_tip,
    output logic      o_rx_ring
);
    logic mark_reg;
    initial begin
        mark_reg = 1'b0;
        o_rx_tip = 1'b0;
        o_rx_ring = 1'b0;
    end
    // A quiet line rests at zero on both wires
    always @(posedge i_mclk) begin
        mark_reg <= ~mark_reg;
        o_rx_tip <= i_send & mark_reg;
        o_rx_ring <= i_send & ~mark_reg;
    end
endmodule

// ==== tb/testbench.sv ====
// Testbench for the line unit channel control block
`timescale 1ns/1ps
`include "lucc_defines.svh"
module testbench;
    import lucc_pkg::*;
    logic i_mclk, i_rst_b, i_wr, i_rd, i_tx_pos, i_tx_neg, send;
    logic [`LUCC_AW-1:0] i_addr;
    logic [7:0] i_wdata, o_rdata, amp;
    logic rx_tip, rx_ring, tx_tip, tx_ring, rx_pos, rx_clk, rx_pd;
    logic e1, coax;
    lucc_haul_e haul;
    lucc_sens_e sens;
    lucc_kind_e kind;
    logic [2:0] line_build_out;
    logic [10:0] x;
    logic s[100];
    int num_errors = 0;
    int tests_run = 0;
    lucc_channel_ctrl lucc_channel_ctrl_i (.i_mclk(i_mclk),
        .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_tx_pos(i_tx_pos), .i_tx_neg(i_tx_neg),
        .i_line_rx_tip(rx_tip), .i_line_rx_ring(rx_ring),
        .o_line_tx_tip(tx_tip), .o_line_tx_ring(tx_ring),
        .o_tx_pulse_amp(amp), .o_rx_positive_data_out(rx_pos),
        .o_rx_clock_out(rx_clk), .o_rx_power_down(rx_pd),
        .o_e1_mode(e1), .o_coax(coax), .o_haul(haul), .o_rx_sens(sens),
        .o_lbo_kind(kind), .o_line_build_out(line_build_out));
    lucc_line_model lucc_line_model_i (.i_mclk(i_mclk), .i_send(send),
        .o_rx_tip(rx_tip), .o_rx_ring(rx_ring));
    initial i_mclk = 1'b0;
    always #50 i_mclk = ~i_mclk;
    task automatic chk(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    task automatic rdc(input string nm, logic [15:0] a, logic [7:0] e);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(nm, e, o_rdata);
        // Read data stands for one cycle only
        @(posedge i_mclk);
        #1 chk({nm, "_drop"}, 8'h00, o_rdata);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rst;
        i_rst_b <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        #1 chk("power_down", 8'h01, {7'h00, rx_pd});
        chk("decode", 8'h00, {e1, coax, haul, sens, kind});
        rdc("ctrl", `LUCC_ADDR_CTRL, `LUCC_CTRL_RST);
        $display("test reset done");
    endtask
    // Returns the status byte and the build-out step for a code
    function automatic logic [10:0] eq_exp(input logic [4:0] c);
        logic e;
        logic [1:0] h, s, k;
        logic [2:0] l;
        e = c[4] & c[3];
        h = c < 8 ? 2'h0 : (c < 14 ? 2'h1 : 2'h2);
        s = c < 4 ? 2'h0 : (c < 8 ? 2'h1 : (c < 14 ? 2'h2 : 2'h3));
        k = (c == 13 || c == 19) ? 2'h2 : ((c < 8 || c > 19) ? 2'h0 : 2'h1);
        // Long haul build-out steps repeat in each group of four codes
        l = 3'(c < 8 ? c[1:0] : (c < 13 ? c - 8 :
                                 (c < 19 ? c - 14 : c - 20)));
        if (e) begin
            h = {c[2] & c[1], c[2] & ~c[1]};
            s = c[2:1];
            k = 2'h3;
        end
        return {e, e & ~c[0], h, s, k, l};
    endfunction
    // Samples one pattern bit per two clocks and checks the recurrence
    task automatic pat(input logic [7:0] ctl, input int sel, deg);
        int f1, f2, ones, ami, lastm;
        logic v;
        f1 = 0;
        f2 = 0;
        ones = 0;
        ami = 0;
        lastm = -1;
        wr(`LUCC_ADDR_CTRL, ctl);
        wr(`LUCC_ADDR_GEN, 8'h01);
        repeat (10) @(posedge i_mclk);
        for (int n = 0; n < 100; n++) begin
            repeat (2) @(posedge i_mclk);
            #1 s[n] = sel ? rx_pos : (tx_tip | tx_ring);
            if (!sel && (tx_tip & tx_ring)) ami++;
            if (!sel && (tx_tip | tx_ring)) begin
                if (lastm == int'(tx_tip)) ami++;
                lastm = int'(tx_tip);
            end
            if (s[n] === 1'b1) ones++;
            if (n >= deg) begin
                v = s[n - deg] ^ s[n - (deg == 15 ? 14 : 17)];
                if (s[n] !== v) f1++;
                if (s[n] !== (s[n - deg] ^ s[n - (deg == 15 ? 1 : 3)])) f2++;
            end
        end
        chk("pattern", 8'h00, 8'((f1 != 0 && f2 != 0) ? 1 : 0));
        chk("active", 8'h01, 8'((ones > 0 && ones < 100) ? 1 : 0));
        chk("alternate", 8'h00, 8'(ami));
        if (sel) begin
            chk("tx_framer", 8'h02, {6'h00, tx_tip, tx_ring});
            v = rx_clk;
            @(posedge i_mclk);
            #1 chk("rx_clock", {7'h00, ~v}, {7'h00, rx_clk});
        end
        wr(`LUCC_ADDR_GEN, 8'h00);
        $display("test pattern %h done", ctl);
    endtask
    task automatic rxw(input logic [7:0] ctl, input logic on);
        int ones;
        ones = 0;
        wr(`LUCC_ADDR_CTRL, ctl);
        repeat (3) @(posedge i_mclk);
        #1 chk("power_down", {7'h00, ~on}, {7'h00, rx_pd});
        for (int n = 0; n < 20; n++) begin
            @(posedge i_mclk);
            #1 if (rx_pos === 1'b1) ones++;
        end
        chk("rx_data", {7'h00, on}, 8'(ones > 0 ? 1 : 0));
        $display("test receive %h done", ctl);
    endtask
    initial begin
        repeat (50000) @(posedge i_mclk);
        num_errors++;
        $display("[ERR] watchdog expected end seen hang");
        results();
    end
    initial begin
        {i_rst_b, i_wr, i_rd, i_addr, i_wdata, i_tx_neg} = '0;
        i_tx_pos = 1'b1;
        send = 1'b1;
        rst();
        wr(`LUCC_ADDR_CTRL, 8'h25);
        rdc("ctrl", `LUCC_ADDR_CTRL, 8'h25);
        wr(16'h0f05, 8'hff);
        rdc("unmapped", 16'h0f05, 8'h00);
        $display("test access done");
        rxw(8'h00, 1'b0);
        rxw(8'h20, 1'b1);
        for (int c = 0; c < 32; c++) begin
            wr(`LUCC_ADDR_CTRL, {3'h1, 5'(c)});
            repeat (3) @(posedge i_mclk);
            x = eq_exp(5'(c));
            #1 chk("decode", x[10:3], {e1, coax, haul, sens, kind});
            if (x[4:3] < 2) chk("lbo", {5'h00, x[2:0]}, {5'h00, line_build_out});
            rdc("status", `LUCC_ADDR_STAT, x[10:3]);
        end
        wr(`LUCC_ADDR_STAT, 8'h00);
        rdc("status_ro", `LUCC_ADDR_STAT, x[10:3]);
        $display("test decode done");
        for (int i = 0; i < 8; i++)
            wr(`LUCC_ADDR_SEG0 + 16'(i), 8'h11 * 8'(i + 1));
        rdc("segment", `LUCC_ADDR_SEG7, 8'h88);
        foreach (x[i]) x[i] = 1'b0;
        for (int c = 13; c < 20; c += 6) begin
            wr(`LUCC_ADDR_CTRL, 8'(c));
            repeat (3) @(posedge i_mclk);
            #1 x = {3'h0, amp};
            for (int i = 1; i < 9; i++) begin
                @(posedge i_mclk);
                #1 chk("amp", 8'h11 * 8'(((x[7:0] / 8'h11) + i - 1) % 8 + 1), amp);
            end
        end
        wr(`LUCC_ADDR_CTRL, 8'h0c);
        repeat (3) @(posedge i_mclk);
        #1 chk("amp_off", 8'h00, amp);
        $display("test pulse done");
        pat(8'h20, 0, 15);
        pat(8'ha0, 0, 20);
        pat(8'he0, 1, 20);
        pat(8'h40, 1, 15);
        rst();
        results();
    end
endmodule
